/* rtl/dac_timing_pkg.sv */
package dac_timing_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W     = 6;
	localparam logic [5:0]  OFS_CTRL   = 6'h00;
	localparam logic [5:0]  OFS_CFG    = 6'h04;
	localparam logic [5:0]  OFS_ROUTE  = 6'h08;
	localparam logic [5:0]  OFS_DIV    = 6'h0c;
	localparam logic [5:0]  OFS_DELAY  = 6'h10;
	localparam logic [5:0]  OFS_COUNT  = 6'h14;
	localparam logic [5:0]  OFS_DATA   = 6'h18;
	localparam logic [5:0]  OFS_STATUS = 6'h1c;
	localparam logic [5:0]  OFS_EXPORT = 6'h20;

	// control register bit positions (write-only pulses)
	localparam int unsigned CTL_START = 0;
	localparam int unsigned CTL_STOP  = 1;
	localparam int unsigned CTL_SWUPD = 2;
	localparam int unsigned CTL_CLR   = 3;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_CFG    = 32'h0000_0000;
	localparam logic [31:0] RST_ROUTE  = 32'h0007_fe30;
	localparam logic [31:0] RST_DIV    = 32'h0000_0014;
	localparam logic [31:0] RST_DELAY  = 32'h0000_0002;
	localparam logic [31:0] RST_COUNT  = 32'h0000_0001;
	localparam logic [31:0] RST_EXPORT = 32'h0000_0000;

	// ----------------------------------------------------------------
	// mode encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] TM_SW     = 2'h0;
	localparam logic [1:0] TM_NONBUF = 2'h1;
	localparam logic [1:0] TM_BUF    = 2'h2;
	localparam logic [1:0] RG_STD    = 2'h0;
	localparam logic [1:0] RG_FIFO   = 2'h1;
	localparam logic [1:0] RG_NONE   = 2'h2;

	// source selects: 0..5 input lines, 6..13 sync bus, 14 star line
	localparam logic [4:0] SRC_EXT_N   = 5'h0f;
	localparam logic [4:0] STRB_CTR    = 5'h0f;
	localparam logic [4:0] STRB_DIV    = 5'h10;
	localparam logic [4:0] TRIG_ISTOP  = 5'h0f;
	localparam logic [4:0] TRIG_IBEGIN = 5'h10;
	localparam logic [4:0] TRIG_SW     = 5'h11;
	localparam logic [4:0] BASE_T20    = 5'h0f;
	localparam logic [4:0] BASE_T100K  = 5'h10;
	localparam logic [4:0] BASE_REF10  = 5'h11;
	localparam int unsigned SEL_N      = 18;

	// ----------------------------------------------------------------
	// register layouts
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [23:0] rsvd;
		logic        gate_low;
		logic        trig_fall;
		logic        strb_fall;
		logic [1:0]  regen;
		logic        cont;
		logic [1:0]  tmode;
	} cfg_s;

	typedef struct packed {
		logic [11:0] rsvd;
		logic [4:0]  base;
		logic [4:0]  gate;
		logic [4:0]  trig;
		logic [4:0]  strb;
	} route_s;

	typedef struct packed {
		logic [7:0] gate_sync;
		logic [7:0] strb_sync;
		logic [3:0] strb_pfi;
		logic [7:0] trig_sync;
		logic [3:0] trig_pfi;
	} export_s;

	typedef struct packed {
		logic [15:0] rsvd;
		logic [7:0]  level;
		logic [1:0]  rsvd2;
		logic        empty;
		logic        full;
		logic        done;
		logic        underflow;
		logic        armed;
		logic        running;
	} status_s;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ARMED = 2'b01,
		ST_DELAY = 2'b10,
		ST_RUN   = 2'b11
	} gen_state_e;

endpackage : dac_timing_pkg

/* rtl/dac_waveform_timing_engine.sv */
`timescale 1ns/1ps
module dac_waveform_timing_engine #(
	parameter int unsigned NCH   = 4,
	parameter int unsigned DW    = 8,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic                 sys_clk_i,
	input  wire logic                 sys_rst_i,
	input  wire logic [5:0]           address_i,
	input  wire logic                 read_i,
	input  wire logic                 write_i,
	input  wire logic [3:0]           byteenable_i,
	input  wire logic [31:0]          writedata_i,
	output logic [31:0]               readdata_o,
	output logic                      waitrequest_o,
	input  wire logic [5:0]           pfi_in_i,
	input  wire logic [7:0]           sync_in_i,
	input  wire logic                 star_i,
	input  wire logic                 counter_out_i,
	input  wire logic                 input_stop_trigger_i,
	input  wire logic                 input_begin_trigger_i,
	input  wire logic                 tb20m_i,
	input  wire logic                 tb100k_i,
	input  wire logic                 ref10m_i,
	output logic [3:0]                pfi_out_o,
	output logic [7:0]                sync_out_o,
	output logic [7:0]                sync_oe_o,
	output logic [NCH*DW-1:0]         dac_o,
	output logic                      dac_update_o
);
	localparam int unsigned PW = $clog2(DEPTH);
	localparam int unsigned CW = $clog2(DEPTH+1);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic sel_line(input logic [17:0] v, input logic [4:0] s);
		sel_line = (32'(s) < dac_timing_pkg::SEL_N) ? v[s] : 1'b0;
	endfunction : sel_line

	function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] be);
		for (int b = 0; b < 4; b++) begin
			o[b*8 +: 8] = be[b] ? n[b*8 +: 8] : o[b*8 +: 8];
		end
		be_merge = o;
	endfunction : be_merge

	// ----------------------------------------------------------------
	// registers and state
	// ----------------------------------------------------------------
	dac_timing_pkg::cfg_s       cfg_r;
	dac_timing_pkg::route_s     route_r;
	dac_timing_pkg::export_s    exp_r;
	dac_timing_pkg::gen_state_e state_r;
	logic [31:0]                div_r;
	logic [31:0]                delay_r;
	logic [31:0]                count_r;
	logic [31:0]                remain_r;
	logic [31:0]                dcnt_r;
	logic                       wrq_r;
	logic [31:0]                rdata_r;
	logic [NCH*DW-1:0]          mem_r [DEPTH];
	logic [PW-1:0]              wp_r;
	logic [PW-1:0]              rp_r;
	logic [CW-1:0]              cnt_r;
	logic [NCH*DW-1:0]          direct_r;
	logic                       pend_r;
	logic [NCH*DW-1:0]          dac_r;
	logic                       dupd_r;
	logic                       uflow_r;
	logic                       done_r;
	logic                       trig_prev_r;
	logic                       strb_prev_r;
	logic                       base_prev_r;
	logic [3:0]                 pfi_r;
	logic [7:0]                 sync_r;
	logic [7:0]                 oe_r;

	logic [14:0] ext_v;
	logic        acc_wr, acc_rd, start_p, stop_p, swupd_p, clr_p, dwr;
	logic        trig_lvl, strb_lvl, base_lvl, gate_act, base_tick, internal;
	logic        trig_evt, strb_edge, int_strb, strb_evt, upd_evt;
	logic        full, empty, lock, push, pop, rot, uflow_evt, fin_evt;
	logic [31:0] rd_v;
	dac_timing_pkg::status_s st_v;

	// ----------------------------------------------------------------
	// bus access decode
	// ----------------------------------------------------------------
	always_comb begin
		acc_wr  = write_i & ~wrq_r;
		acc_rd  = read_i & wrq_r;
		start_p = acc_wr & (address_i == dac_timing_pkg::OFS_CTRL) & byteenable_i[0]
			& writedata_i[dac_timing_pkg::CTL_START];
		stop_p  = acc_wr & (address_i == dac_timing_pkg::OFS_CTRL) & byteenable_i[0]
			& writedata_i[dac_timing_pkg::CTL_STOP];
		swupd_p = acc_wr & (address_i == dac_timing_pkg::OFS_CTRL) & byteenable_i[0]
			& writedata_i[dac_timing_pkg::CTL_SWUPD] & (cfg_r.tmode == dac_timing_pkg::TM_SW);
		clr_p   = acc_wr & (address_i == dac_timing_pkg::OFS_CTRL) & byteenable_i[0]
			& writedata_i[dac_timing_pkg::CTL_CLR];
		dwr     = acc_wr & (address_i == dac_timing_pkg::OFS_DATA);
	end

	// ----------------------------------------------------------------
	// source selection and event detection
	// ----------------------------------------------------------------
	always_comb begin
		ext_v     = {star_i, sync_in_i, pfi_in_i};
		trig_lvl  = sel_line({1'b0, input_begin_trigger_i, input_stop_trigger_i, ext_v}, route_r.trig);
		strb_lvl  = sel_line({2'b00, counter_out_i, ext_v}, route_r.strb);
		base_lvl  = sel_line({ref10m_i, tb100k_i, tb20m_i, ext_v}, route_r.base);
		gate_act  = (route_r.gate < dac_timing_pkg::SRC_EXT_N)
			& (sel_line({3'b000, ext_v}, route_r.gate) ^ cfg_r.gate_low);
		base_tick = base_lvl & ~base_prev_r;
		internal  = (route_r.strb == dac_timing_pkg::STRB_DIV);
		trig_evt  = (route_r.trig == dac_timing_pkg::TRIG_SW) ? 1'b1
			: (cfg_r.trig_fall ? (trig_prev_r & ~trig_lvl) : (~trig_prev_r & trig_lvl));
		strb_edge = cfg_r.strb_fall ? (strb_prev_r & ~strb_lvl) : (~strb_prev_r & strb_lvl);
		int_strb  = internal & base_tick & (dcnt_r <= 32'h1)
			& ((state_r == dac_timing_pkg::ST_DELAY) | ((state_r == dac_timing_pkg::ST_RUN) & ~gate_act));
		strb_evt  = internal ? int_strb : strb_edge;
		upd_evt   = strb_evt & ~gate_act & (cfg_r.tmode != dac_timing_pkg::TM_SW)
			& ((state_r == dac_timing_pkg::ST_RUN) | (state_r == dac_timing_pkg::ST_DELAY));
		full      = (cnt_r == CW'(DEPTH));
		empty     = (cnt_r == '0);
		lock      = (state_r != dac_timing_pkg::ST_IDLE) & (cfg_r.regen == dac_timing_pkg::RG_FIFO);
		push      = dwr & (cfg_r.tmode == dac_timing_pkg::TM_BUF) & ~full & ~lock;
		pop       = upd_evt & (cfg_r.tmode == dac_timing_pkg::TM_BUF) & ~empty;
		rot       = pop & (cfg_r.regen == dac_timing_pkg::RG_FIFO);
		uflow_evt = upd_evt & (cfg_r.tmode == dac_timing_pkg::TM_BUF) & empty
			& (cfg_r.regen == dac_timing_pkg::RG_NONE);
		fin_evt   = upd_evt & ~cfg_r.cont & (remain_r <= 32'h1);
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			trig_prev_r <= 1'b0;
			strb_prev_r <= 1'b0;
			base_prev_r <= 1'b0;
		end else begin
			trig_prev_r <= trig_lvl;
			strb_prev_r <= strb_lvl;
			base_prev_r <= base_lvl;
		end
	end

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			cfg_r   <= dac_timing_pkg::RST_CFG;
			route_r <= dac_timing_pkg::RST_ROUTE;
			div_r   <= dac_timing_pkg::RST_DIV;
			delay_r <= dac_timing_pkg::RST_DELAY;
			count_r <= dac_timing_pkg::RST_COUNT;
			exp_r   <= dac_timing_pkg::RST_EXPORT;
		end else if (acc_wr) begin
			case (address_i)
				dac_timing_pkg::OFS_CFG:    cfg_r   <= be_merge(cfg_r, writedata_i, byteenable_i);
				dac_timing_pkg::OFS_ROUTE:  route_r <= be_merge(route_r, writedata_i, byteenable_i);
				dac_timing_pkg::OFS_DIV:    div_r   <= be_merge(div_r, writedata_i, byteenable_i);
				dac_timing_pkg::OFS_DELAY:  delay_r <= be_merge(delay_r, writedata_i, byteenable_i);
				dac_timing_pkg::OFS_COUNT:  count_r <= be_merge(count_r, writedata_i, byteenable_i);
				dac_timing_pkg::OFS_EXPORT: exp_r   <= be_merge(exp_r, writedata_i, byteenable_i);
				default: ;
			endcase
		end
	end

	always_comb begin
		st_v           = '0;
		st_v.running   = (state_r == dac_timing_pkg::ST_RUN) | (state_r == dac_timing_pkg::ST_DELAY);
		st_v.armed     = (state_r == dac_timing_pkg::ST_ARMED);
		st_v.underflow = uflow_r;
		st_v.done      = done_r;
		st_v.full      = full;
		st_v.empty     = empty;
		st_v.level     = 8'(cnt_r);
		case (address_i)
			dac_timing_pkg::OFS_CFG:    rd_v = cfg_r;
			dac_timing_pkg::OFS_ROUTE:  rd_v = route_r;
			dac_timing_pkg::OFS_DIV:    rd_v = div_r;
			dac_timing_pkg::OFS_DELAY:  rd_v = delay_r;
			dac_timing_pkg::OFS_COUNT:  rd_v = count_r;
			dac_timing_pkg::OFS_STATUS: rd_v = st_v;
			dac_timing_pkg::OFS_EXPORT: rd_v = exp_r;
			default:                    rd_v = 32'h0;
		endcase
	end

	// one wait state on every access, read data loaded on the waiting cycle
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			wrq_r   <= 1'b1;
			rdata_r <= 32'h0;
		end else begin
			wrq_r <= ~((read_i | write_i) & wrq_r);
			if (acc_rd) begin
				rdata_r <= rd_v;
			end
		end
	end

	// ----------------------------------------------------------------
	// generation sequencer and strobe divider
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			state_r  <= dac_timing_pkg::ST_IDLE;
			remain_r <= 32'h0;
			dcnt_r   <= 32'h0;
		end else if (stop_p) begin
			state_r <= dac_timing_pkg::ST_IDLE;
		end else begin
			case (state_r)
				dac_timing_pkg::ST_IDLE: begin
					if (start_p) begin
						state_r  <= dac_timing_pkg::ST_ARMED;
						remain_r <= count_r;
					end
				end
				dac_timing_pkg::ST_ARMED: begin
					if (trig_evt) begin
						state_r <= internal ? dac_timing_pkg::ST_DELAY : dac_timing_pkg::ST_RUN;
						dcnt_r  <= delay_r;
					end
				end
				default: begin
					if (fin_evt | uflow_evt) begin
						state_r <= dac_timing_pkg::ST_IDLE;
					end else if (int_strb) begin
						state_r <= dac_timing_pkg::ST_RUN;
						dcnt_r  <= div_r;
					end else if (base_tick & ~(gate_act & (state_r == dac_timing_pkg::ST_RUN))) begin
						dcnt_r <= dcnt_r - 32'h1;
					end
					if (upd_evt) begin
						remain_r <= remain_r - 32'h1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			uflow_r <= 1'b0;
			done_r  <= 1'b0;
		end else begin
			uflow_r <= uflow_evt | (uflow_r & ~clr_p);
			done_r  <= (fin_evt & (state_r != dac_timing_pkg::ST_IDLE)) | (done_r & ~clr_p);
		end
	end

	// ----------------------------------------------------------------
	// output sample queue
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else if (rot) begin
			mem_r[wp_r] <= mem_r[rp_r];
			wp_r        <= wp_r + PW'(1);
			rp_r        <= rp_r + PW'(1);
		end else begin
			if (push) begin
				mem_r[wp_r] <= writedata_i[NCH*DW-1:0];
				wp_r        <= wp_r + PW'(1);
			end
			if (pop) begin
				rp_r <= rp_r + PW'(1);
			end
			cnt_r <= cnt_r + CW'(push) - CW'(pop);
		end
	end

	// ----------------------------------------------------------------
	// dac load
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			direct_r <= '0;
			pend_r   <= 1'b0;
			dac_r    <= '0;
			dupd_r   <= 1'b0;
		end else begin
			if (dwr & (cfg_r.tmode != dac_timing_pkg::TM_BUF)) begin
				direct_r <= writedata_i[NCH*DW-1:0];
			end
			pend_r <= (dwr & (cfg_r.tmode == dac_timing_pkg::TM_NONBUF))
				| (pend_r & ~(upd_evt & (cfg_r.tmode == dac_timing_pkg::TM_NONBUF)));
			dupd_r <= swupd_p | pop | (upd_evt & pend_r & (cfg_r.tmode == dac_timing_pkg::TM_NONBUF));
			if (swupd_p) begin
				dac_r <= direct_r;
			end else if (pop) begin
				dac_r <= mem_r[rp_r];
			end else if (upd_evt & pend_r & (cfg_r.tmode == dac_timing_pkg::TM_NONBUF)) begin
				dac_r <= direct_r;
			end
		end
	end

	// ----------------------------------------------------------------
	// signal export
	// ----------------------------------------------------------------
	generate
		for (genvar i = 0; i < 4; i++) begin : g_pfi
			always_ff @(posedge sys_clk_i) begin
				if (sys_rst_i) begin
					pfi_r[i] <= 1'b0;
				end else begin
					pfi_r[i] <= exp_r.trig_pfi[i] ? ((state_r == dac_timing_pkg::ST_ARMED) & trig_evt)
						: (exp_r.strb_pfi[i] & ~upd_evt);
				end
			end
		end
		for (genvar i = 0; i < 8; i++) begin : g_sync
			always_ff @(posedge sys_clk_i) begin
				if (sys_rst_i) begin
					sync_r[i] <= 1'b0;
					oe_r[i]   <= 1'b0;
				end else begin
					oe_r[i]   <= exp_r.trig_sync[i] | exp_r.strb_sync[i] | exp_r.gate_sync[i];
					sync_r[i] <= exp_r.trig_sync[i] ? ((state_r == dac_timing_pkg::ST_ARMED) & trig_evt)
						: exp_r.strb_sync[i] ? ~upd_evt
						: (exp_r.gate_sync[i] & gate_act);
				end
			end
		end
	endgenerate

	always_comb begin
		readdata_o    = rdata_r;
		waitrequest_o = wrq_r;
		dac_o         = dac_r;
		dac_update_o  = dupd_r;
		pfi_out_o     = pfi_r;
		sync_out_o    = sync_r;
		sync_oe_o     = oe_r;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_armed_trig;
		(state_r == dac_timing_pkg::ST_ARMED) && trig_evt && internal && !stop_p;
	endsequence

	property p_pop_loads;
		pop && !swupd_p |=> dupd_r && (dac_r == $past(mem_r[rp_r]));
	endproperty
	a_pop_loads: assert property (p_pop_loads) else $error("pop did not load dac");

	property p_sw_update;
		swupd_p |=> dupd_r && (dac_r == $past(direct_r));
	endproperty
	a_sw_update: assert property (p_sw_update) else $error("software update lost");

	property p_no_early;
		(state_r == dac_timing_pkg::ST_ARMED) && !swupd_p |=> !dupd_r;
	endproperty
	a_no_early: assert property (p_no_early) else $error("update before trigger");

	property p_gate_mask;
		gate_act && !swupd_p |=> !dupd_r;
	endproperty
	a_gate_mask: assert property (p_gate_mask) else $error("update while gated");

	property p_finite_end;
		fin_evt && !stop_p |=> (state_r == dac_timing_pkg::ST_IDLE) && done_r;
	endproperty
	a_finite_end: assert property (p_finite_end) else $error("finite run did not end");

	property p_underflow;
		uflow_evt |=> uflow_r && (state_r == dac_timing_pkg::ST_IDLE);
	endproperty
	a_underflow: assert property (p_underflow) else $error("underflow not reported");

	property p_regen_keep;
		rot |=> (cnt_r == $past(cnt_r));
	endproperty
	a_regen_keep: assert property (p_regen_keep) else $error("regeneration lost data");

	property p_delay_first;
		s_armed_trig |=> (state_r == dac_timing_pkg::ST_DELAY) && (dcnt_r == $past(delay_r));
	endproperty
	a_delay_first: assert property (p_delay_first) else $error("start delay not loaded");

	property p_full_refuse;
		dwr && full |=> (cnt_r == $past(cnt_r)) || $past(pop);
	endproperty
	a_full_refuse: assert property (p_full_refuse) else $error("write into full queue");

	property p_bus_answer;
		(read_i || write_i) && wrq_r |=> !wrq_r ##1 wrq_r;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing wrong");

endmodule : dac_waveform_timing_engine

/* verification/host_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// host software side: bus master that fills the sample queue
// ----------------------------------------------------------------
module host_model (
	input  wire logic        clk_i,
	input  wire logic        wait_i,
	input  wire logic [31:0] rdata_i,
	output logic [5:0]       address_o,
	output logic             read_o,
	output logic             write_o,
	output logic [3:0]       be_o,
	output logic [31:0]      wdata_o
);
	initial begin
		address_o = 6'h00;
		read_o = 1'b0;
		write_o = 1'b0;
		be_o = 4'hf;
		wdata_o = 32'h0000_0000;
	end
	// request held until waitrequest is sampled low
	task automatic xfer(input logic rd, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		address_o <= a;
		wdata_o <= d;
		read_o <= rd;
		write_o <= ~rd;
		@(posedge clk_i);
		while (wait_i !== 1'b0)
			@(posedge clk_i);
		q = rdata_i;
		read_o <= 1'b0;
		write_o <= 1'b0;
		wdata_o <= ~d;
	endtask : xfer
	// samples are loaded before start and, in the tests, after start too
	task automatic push(input logic [31:0] s);
		logic [31:0] q;
		xfer(1'b0, dac_timing_pkg::OFS_DATA, s, q);
	endtask : push
	task automatic start();
		logic [31:0] q;
		xfer(1'b0, dac_timing_pkg::OFS_CTRL, 32'h0000_0001, q);
	endtask : start
endmodule : host_model

/* verification/dac_waveform_timing_engine_test.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; $display("ERROR %0t value %h expected %h", $time, (a), (b)); end end
module dac_waveform_timing_engine_test;
	// ----------------------------------------------------------------
	// stimulus and monitor
	// ----------------------------------------------------------------
	logic        sys_clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [5:0]  addr;
	logic        rd, wr;
	logic [3:0]  be;
	logic [31:0] wd, rdata, q, s;
	logic        wreq, star, ctr, istop, ibeg, t100, r10;
	logic        t20 = 1'b0;
	logic [5:0]  pfi_in = 6'h00;
	logic [7:0]  sync_in = 8'h00;
	logic [31:0] dac;
	logic        upd;
	logic [3:0]  pfo;
	logic [7:0]  synco, synoe;
	logic [31:0] got[$], expq[$];
	int          n_mismatch = 0, n_checks = 0, cyc = 0, n_low = 0, n_hi = 0;
	logic [5:0]  ofs[7] = '{6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h20, 6'h3c};
	logic [31:0] rv[7] = '{32'h0, 32'h0007_fe30, 32'h14, 32'h2, 32'h1, 32'h0, 32'h0};
	initial {star, ctr, istop, ibeg, t100, r10} = 6'h00;
	always #20 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		t20 <= ~t20;
		{sync_in, star, ctr, istop, ibeg, t100, r10} <= 14'($urandom);
		pfi_in[5:1] <= 5'($urandom);
		if (upd === 1'b1)
			got.push_back(dac);
		n_low += int'(pfo[0] === 1'b0);
		n_hi += int'(pfo[1] === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			final_report();
		end
	end
	host_model host_model_inst (.clk_i(sys_clk_i), .wait_i(wreq), .rdata_i(rdata), .address_o(addr),
		.read_o(rd), .write_o(wr), .be_o(be), .wdata_o(wd));
	dac_waveform_timing_engine #(.NCH(4), .DW(8), .DEPTH(16)) dac_waveform_timing_engine_inst (
		.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .address_i(addr), .read_i(rd), .write_i(wr),
		.byteenable_i(be), .writedata_i(wd), .readdata_o(rdata), .waitrequest_o(wreq), .pfi_in_i(pfi_in),
		.sync_in_i(sync_in), .star_i(star), .counter_out_i(ctr), .input_stop_trigger_i(istop),
		.input_begin_trigger_i(ibeg), .tb20m_i(t20), .tb100k_i(t100), .ref10m_i(r10), .pfi_out_o(pfo),
		.sync_out_o(synco), .sync_oe_o(synoe), .dac_o(dac), .dac_update_o(upd));
	function automatic logic [31:0] cfg_word(logic [1:0] tm, logic cont, logic [1:0] rg);
		return {27'h0, rg, cont, tm};
	endfunction : cfg_word
	task automatic wrr(input logic [5:0] a, input logic [31:0] d);
		host_model_inst.xfer(1'b0, a, d, q);
	endtask : wrr
	task automatic fill(input int n);
		expq.delete();
		got.delete();
		for (int i = 0; i < n; i++) begin
			s = $urandom;
			expq.push_back(s);
			host_model_inst.push(s);
		end
	endtask : fill
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(57));
		repeat (20) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			host_model_inst.xfer(1'b1, ofs[i], 32'h0, q);
			`CHK(q, rv[i])
		end
		$display("test reset values ended");
		s = $urandom;
		wrr(dac_timing_pkg::OFS_DATA, s);
		got.delete();
		wrr(dac_timing_pkg::OFS_CTRL, 32'h4);
		repeat (6) @(posedge sys_clk_i);
		`CHK(32'(got.size()), 32'd1)
		`CHK(got[0], s)
		$display("test software update ended");
		wrr(dac_timing_pkg::OFS_CFG, cfg_word(dac_timing_pkg::TM_BUF, 1'b0, dac_timing_pkg::RG_STD));
		wrr(dac_timing_pkg::OFS_DIV, 32'h2);
		wrr(dac_timing_pkg::OFS_COUNT, 32'h3);
		wrr(dac_timing_pkg::OFS_CTRL, 32'h8);
		fill(3);
		`CHK(32'(got.size()), 32'd0)
		host_model_inst.start();
		repeat (60) @(posedge sys_clk_i);
		`CHK(32'(got.size()), 32'd3)
		for (int i = 0; i < 3; i++)
			`CHK(got[i], expq[i])
		host_model_inst.xfer(1'b1, dac_timing_pkg::OFS_STATUS, 32'h0, q);
		`CHK(q[3], 1'b1)
		$display("test buffered finite ended");
		wrr(dac_timing_pkg::OFS_CTRL, 32'ha);
		wrr(dac_timing_pkg::OFS_ROUTE, 32'h0007_8230);
		wrr(dac_timing_pkg::OFS_EXPORT, 32'h0100_0000);
		pfi_in[0] <= 1'b1;
		fill(2);
		host_model_inst.start();
		repeat (40) @(posedge sys_clk_i);
		`CHK(32'(got.size()), 32'd0)
		`CHK(synco[0], 1'b1)
		`CHK(synoe[0], 1'b1)
		pfi_in[0] <= 1'b0;
		repeat (40) @(posedge sys_clk_i);
		`CHK(32'(got.size()), 32'd2)
		`CHK(synco[0], 1'b0)
		$display("test hold gate ended");
		wrr(dac_timing_pkg::OFS_CTRL, 32'ha);
		wrr(dac_timing_pkg::OFS_ROUTE, 32'h0007_fe30);
		wrr(dac_timing_pkg::OFS_CFG, cfg_word(dac_timing_pkg::TM_BUF, 1'b1, dac_timing_pkg::RG_NONE));
		fill(2);
		host_model_inst.start();
		repeat (40) @(posedge sys_clk_i);
		`CHK(32'(got.size()), 32'd2)
		host_model_inst.xfer(1'b1, dac_timing_pkg::OFS_STATUS, 32'h0, q);
		`CHK(q[2], 1'b1)
		`CHK(q[5], 1'b1)
		$display("test underflow ended");
		wrr(dac_timing_pkg::OFS_CTRL, 32'ha);
		wrr(dac_timing_pkg::OFS_ROUTE, 32'h0007_fe20);
		wrr(dac_timing_pkg::OFS_CFG, cfg_word(dac_timing_pkg::TM_BUF, 1'b0, dac_timing_pkg::RG_STD) | 32'h20);
		fill(3);
		host_model_inst.start();
		for (int i = 0; i < 3; i++) begin
			pfi_in[0] <= 1'b1;
			repeat (4) @(posedge sys_clk_i);
			`CHK(32'(got.size()), 32'(i))
			pfi_in[0] <= 1'b0;
			repeat (4) @(posedge sys_clk_i);
		end
		`CHK(32'(got.size()), 32'd3)
		for (int i = 0; i < 3; i++)
			`CHK(got[i], expq[i])
		$display("test external strobe ended");
		wrr(dac_timing_pkg::OFS_ROUTE, 32'h0007_fe30);
		wrr(dac_timing_pkg::OFS_CFG, cfg_word(dac_timing_pkg::TM_NONBUF, 1'b1, dac_timing_pkg::RG_STD));
		host_model_inst.start();
		got.delete();
		s = $urandom;
		wrr(dac_timing_pkg::OFS_DATA, s);
		repeat (12) @(posedge sys_clk_i);
		`CHK(32'(got.size()), 32'd1)
		`CHK(got[0], s)
		$display("test non-buffered ended");
		wrr(dac_timing_pkg::OFS_CTRL, 32'ha);
		wrr(dac_timing_pkg::OFS_CFG, cfg_word(dac_timing_pkg::TM_BUF, 1'b1, dac_timing_pkg::RG_FIFO));
		wrr(dac_timing_pkg::OFS_EXPORT, 32'h0000_1002);
		fill(16);
		host_model_inst.push(32'h0);
		host_model_inst.xfer(1'b1, dac_timing_pkg::OFS_STATUS, 32'h0, q);
		`CHK(q[4], 1'b1)
		`CHK(q[15:8], 8'h10)
		n_low = 0;
		n_hi = 0;
		host_model_inst.start();
		repeat (40) @(posedge sys_clk_i);
		host_model_inst.push(32'h0);
		repeat (40) @(posedge sys_clk_i);
		wrr(dac_timing_pkg::OFS_CTRL, 32'h2);
		host_model_inst.xfer(1'b1, dac_timing_pkg::OFS_STATUS, 32'h0, q);
		`CHK(q[15:8], 8'h10)
		`CHK(32'(got.size() > 16), 32'd1)
		for (int i = 0; i < got.size(); i++)
			`CHK(got[i], expq[i % 16])
		`CHK(32'(n_low), 32'(got.size()))
		`CHK(n_hi, 1)
		$display("test fifo regeneration ended");
		final_report();
	end
endmodule : dac_waveform_timing_engine_test
